/* File: dv/bbc_host_model.sv */
`timescale 1ns/10ps
module bbc_host_model (
  // link clock
  input  wire logic         i_link_clk,
  // handshake
  input  wire logic         i_link_ready,
  output logic              o_link_req,
  output bbc_pkg::bbc_req_s o_link_cmd
);
  import bbc_pkg::*;

  initial begin
    o_link_req = 1'b0;
    o_link_cmd = '0;
  end

  // ---------------------------------------------------------------
  // one transfer: held until taken, then wait for the answer
  // ---------------------------------------------------------------
  // ready is looked at on the falling edge, where it is settled for the
  // rising edge that takes the command
  task automatic xfer(input logic wr, input logic [7:0] addr,
                      input logic [7:0] data, output bit ok);
    bbc_req_s cmd;
    int       n;
    cmd = '{wr: wr, addr: addr, data: data};
    n = 0;
    @(posedge i_link_clk);
    o_link_req <= 1'b1;
    o_link_cmd <= cmd;
    @(negedge i_link_clk);
    while (i_link_ready !== 1'b1 && n < 100) begin
      n++;
      @(negedge i_link_clk);
    end
    @(posedge i_link_clk);
    // released lines show the inverse, not the stale command
    o_link_req <= 1'b0;
    o_link_cmd <= ~cmd;
    @(negedge i_link_clk);
    while (i_link_ready !== 1'b1 && n < 200) begin
      n++;
      @(negedge i_link_clk);
    end
    ok = (n < 200);
  endtask
endmodule

/* File: dv/bbc_top_tb.sv */
`timescale 1ns/10ps
module bbc_top_tb;
  import bbc_pkg::*;
  localparam int TMO = 200;

  logic            i_clk           = 1'b0;
  logic            i_link_clk      = 1'b0;
  logic            i_arst_n        = 1'b0;
  logic            i_pwm           = 1'b0;
  logic            i_bias_pin      = 1'b0;
  logic            i_default_sel   = 1'b0;
  logic            i_rails_ready   = 1'b0;
  logic            i_outputs_off   = 1'b0;
  logic            i_boost_settled = 1'b0;
  logic            i_fault         = 1'b0;
  logic            pwm_run         = 1'b0;
  logic [5:0]      pwm_cnt         = 6'h0;
  logic            link_req;
  bbc_req_s        link_cmd;
  logic            o_link_ready;
  logic            o_link_rvalid;
  logic [7:0]      o_link_rdata;
  logic            o_sink1_en;
  logic            o_sink2_en;
  logic            o_bias_boost_en;
  logic [BW-1:0]   o_brightness;
  logic            o_notify_out;
  logic            o_notify_oe;
  logic [7:0]      exp_q[$];
  int              n_mismatch      = 0;
  int              samples_checked = 0;
  logic [7:0]      lo;
  logic [7:0]      hi;

  always #12.5 i_clk = ~i_clk;
  initial begin
    #7;
    forever #32 i_link_clk = ~i_link_clk;
  end

  // pwm: 10 high of 40 cycles gives a duty code of 0x200
  always @(posedge i_clk) begin
    pwm_cnt <= (pwm_cnt == 6'h27) ? 6'h0 : pwm_cnt + 6'h1;
    i_pwm   <= pwm_run && (pwm_cnt < 6'h0a);
  end

  bbc_top #(.PWM_TIMEOUT(TMO)) u_dut (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_link_clk(i_link_clk),
    .i_link_req(link_req), .i_link_cmd(link_cmd),
    .o_link_ready(o_link_ready), .o_link_rvalid(o_link_rvalid),
    .o_link_rdata(o_link_rdata), .i_pwm(i_pwm), .i_bias_pin(i_bias_pin),
    .i_default_sel(i_default_sel), .i_rails_ready(i_rails_ready),
    .i_outputs_off(i_outputs_off), .i_boost_settled(i_boost_settled),
    .i_fault(i_fault), .o_sink1_en(o_sink1_en), .o_sink2_en(o_sink2_en),
    .o_bias_boost_en(o_bias_boost_en), .o_brightness(o_brightness),
    .o_notify_out(o_notify_out), .o_notify_oe(o_notify_oe));

  bbc_host_model u_host (
    .i_link_clk(i_link_clk), .i_link_ready(o_link_ready),
    .o_link_req(link_req), .o_link_cmd(link_cmd));

  // ---------------------------------------------------------------
  // checking
  // ---------------------------------------------------------------
  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t output %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t read %h expected %h", $time, got, exp);
    end
  endtask

  always @(negedge i_link_clk) begin
    if (o_link_rvalid === 1'b1) begin
      if (exp_q.size() == 0) chk_rd(o_link_rdata, 8'hxx);
      else chk_rd(o_link_rdata, exp_q.pop_front());
    end
  end

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
    bit ok;
    u_host.xfer(w, a, d, ok);
    if (!ok) begin
      n_mismatch++;
      $display("[FAIL] %0t link handshake hung", $time);
      results();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    exp_q.push_back(exp);
    xfer(1'b0, a, 8'h00);
  endtask

  task automatic wait_bl(input logic on, input logic [10:0] b);
    int n;
    n = 0;
    @(negedge i_clk);
    while (!(o_sink1_en === on && o_brightness === b) && n < 12000) begin
      n++;
      @(negedge i_clk);
    end
    chk({10'h0, o_sink1_en}, {10'h0, on});
    chk(o_brightness, b);
    if (n >= 12000) results();
  endtask

  task automatic settle();
    repeat (10) @(negedge i_clk);
  endtask

  task automatic do_reset();
    @(posedge i_clk);
    i_arst_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (20) @(posedge i_clk);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h090b));
    do_reset();
    rd(ADDR_CTRL, CTRL_DEF_A);
    rd(ADDR_BRT_HI, BRT_HI_DEF_A);
    rd(ADDR_BRT_LO, BRT_LO_DEF_A);
    wait_bl(1'b0, 11'h000);
    chk({10'h0, o_notify_oe}, 11'h000);
    @(posedge i_clk);
    i_fault <= 1'b1;
    settle();
    chk({10'h0, o_notify_oe}, 11'h001);
    chk({10'h0, o_notify_out}, 11'h000);
    @(posedge i_clk);
    i_fault         <= 1'b0;
    i_outputs_off   <= 1'b1;
    i_boost_settled <= 1'b1;
    wait_bl(1'b1, 11'h400);
    chk({10'h0, o_notify_oe}, 11'h001);
    @(posedge i_clk);
    i_outputs_off <= 1'b0;
    i_rails_ready <= 1'b1;
    wr(ADDR_CTRL, 8'h01);
    settle();
    chk({9'h0, o_sink1_en, o_sink2_en}, 11'h002);
    wr(ADDR_CTRL, 8'h11);
    settle();
    chk({9'h0, o_sink1_en, o_sink2_en}, 11'h003);
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clk);
      i_bias_pin <= k[1];
      wr(ADDR_CTRL, 8'h11 | {4'h0, k[0], 3'h0});
      settle();
      chk({10'h0, o_bias_boost_en}, {10'h0, k != 0});
    end
    @(posedge i_clk);
    i_bias_pin <= 1'b0;
    lo = 8'($urandom);
    hi = 8'h01 + 8'($urandom % 255);
    wr(ADDR_BRT_LO, lo);
    settle();
    chk(o_brightness, 11'h400);
    rd(ADDR_BRT_LO, lo);
    wr(ADDR_BRT_HI, hi);
    wait_bl(1'b1, {hi, lo[2:0]});
    wr(ADDR_CTRL, 8'h10);
    wait_bl(1'b0, 11'h000);
    wr(ADDR_CTRL, 8'h11);
    wr(ADDR_BRT_LO, 8'h00);
    wr(ADDR_BRT_HI, 8'h00);
    wait_bl(1'b0, 11'h000);
    @(posedge i_clk);
    pwm_run <= 1'b1;
    wr(ADDR_CTRL, 8'h13);
    wait_bl(1'b1, 11'h200);
    wr(ADDR_BRT_HI, 8'h80);
    wr(ADDR_CTRL, 8'h15);
    wait_bl(1'b1, 11'h100);
    wr(ADDR_CTRL, 8'h17);
    wait_bl(1'b1, 11'h100);
    @(posedge i_clk);
    pwm_run <= 1'b0;
    wait_bl(1'b0, 11'h000);
    wr(ADDR_CTRL, 8'h13);
    wait_bl(1'b0, 11'h000);
    rd(ADDR_STAT, 8'h06);
    wr(ADDR_CTRL, 8'h11);
    wait_bl(1'b1, 11'h400);
    wr(ADDR_STAT, 8'hff);
    rd(ADDR_STAT, 8'h03);
    rd(8'h30, 8'h00);
    wr(ADDR_CTRL, 8'hf1);
    rd(ADDR_CTRL, 8'h11);
    @(posedge i_clk);
    i_default_sel <= 1'b1;
    repeat (4) @(posedge i_clk);
    do_reset();
    rd(ADDR_CTRL, CTRL_DEF_B);
    rd(ADDR_BRT_HI, BRT_HI_DEF_B);
    rd(ADDR_BRT_LO, BRT_LO_DEF_B);
    repeat (4) @(negedge i_link_clk);
    if (exp_q.size() != 0) chk_rd(8'h00, 8'hxx);
    results();
  end
endmodule

/* File: rtl/bbc_pkg.sv */
package bbc_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ          = 40_000_000;
  localparam int PWM_TIMEOUT_MS  = 24;
  localparam int PWM_TIMEOUT_CYC = PWM_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int SLOPE_STEP_CYC  = 4;
  localparam int CW              = 20;
  localparam int BW              = 11;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_BRT_LO = 8'h01;
  localparam logic [7:0] ADDR_BRT_HI = 8'h02;
  localparam logic [7:0] ADDR_CTRL   = 8'h0A;
  localparam logic [7:0] ADDR_STAT   = 8'h0B;

  // two factory default sets
  localparam logic [7:0] CTRL_DEF_A   = 8'h11;
  localparam logic [7:0] CTRL_DEF_B   = 8'h17;
  localparam logic [7:0] BRT_HI_DEF_A = 8'h80;
  localparam logic [7:0] BRT_LO_DEF_A = 8'h00;
  localparam logic [7:0] BRT_HI_DEF_B = 8'hFF;
  localparam logic [7:0] BRT_LO_DEF_B = 8'h07;

  localparam logic [1:0] SRC_REG      = 2'h0;
  localparam logic [1:0] SRC_PWM      = 2'h1;
  localparam logic [1:0] SRC_MUL_PRE  = 2'h2;
  localparam logic [1:0] SRC_MUL_POST = 2'h3;

  localparam logic [BW-1:0] DUTY_FULL = 11'h7FF;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] rsvd;
    logic       sink2_en;
    logic       bias_en;
    logic [1:0] src_sel;
    logic       backlight_on_bit;
  } bbc_ctrl_s;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } bbc_req_s;

  typedef struct packed {
    logic fault;
    logic pwm_timeout;
    logic bias_ready;
    logic bl_on;
  } bbc_stat_s;

endpackage

/* File: rtl/bbc_pwm_meas.sv */
`timescale 1ns/10ps
module bbc_pwm_meas #(
  parameter logic [bbc_pkg::CW-1:0] TIMEOUT_CYC = 20'h0_1000
) (
  // clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_rst_n,
  // control and input
  input  wire logic                    i_en,
  input  wire logic                    i_pwm,
  // result
  output logic      [bbc_pkg::BW-1:0]  o_duty,
  output logic                         o_timeout
);
  import bbc_pkg::*;

  logic          pwm_q;
  logic [CW-1:0] cnt;
  logic [CW-1:0] hi;
  logic [CW:0]   rem;
  logic [CW:0]   r2;
  logic [CW-1:0] den;
  logic [BW-1:0] q;
  logic [3:0]    step;
  logic          rise;
  logic          tout;

  assign rise = i_pwm && !pwm_q;
  assign tout = (cnt == TIMEOUT_CYC);
  assign r2   = {rem[CW-1:0], 1'b0};

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pwm_q <= 1'b0;
      cnt   <= '0;
      hi    <= '0;
    end else if (!i_en) begin
      pwm_q <= 1'b0;
      cnt   <= '0;
      hi    <= '0;
    end else begin
      pwm_q <= i_pwm;
      if (rise) begin
        cnt <= CW'(1);
        hi  <= CW'(1);
      end else begin
        if (!tout) cnt <= cnt + CW'(1);
        if (i_pwm && !tout) hi <= hi + CW'(1);
      end
    end
  end

  // high time over period, one quotient bit per cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rem       <= '0;
      den       <= '0;
      q         <= '0;
      step      <= 4'h0;
      o_duty    <= '0;
      o_timeout <= 1'b0;
    end else if (!i_en) begin
      step      <= 4'h0;
      o_duty    <= '0;
      o_timeout <= 1'b0;
    end else if (tout) begin
      step      <= 4'h0;
      o_duty    <= i_pwm ? DUTY_FULL : '0;
      o_timeout <= !i_pwm;
    end else begin
      o_timeout <= 1'b0;
      if (rise && cnt != '0) begin
        rem  <= {1'b0, hi};
        den  <= cnt;
        q    <= '0;
        step <= 4'hB;
      end else if (step != 4'h0) begin
        step <= step - 4'h1;
        if (r2 >= {1'b0, den}) begin
          rem <= r2 - {1'b0, den};
          q   <= {q[BW-2:0], 1'b1};
          if (step == 4'h1) o_duty <= {q[BW-2:0], 1'b1};
        end else begin
          rem <= r2;
          q   <= {q[BW-2:0], 1'b0};
          if (step == 4'h1) o_duty <= {q[BW-2:0], 1'b0};
        end
      end
    end
  end

endmodule

/* File: rtl/bbc_sync2.sv */
`timescale 1ns/10ps
module bbc_sync2 #(
  parameter int W = 1
) (
  // clock
  input  wire logic         i_clk,
  // data
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta;

  // no reset: valid by the time reset is released
  always_ff @(posedge i_clk) begin
    meta <= i_d;
    o_q  <= meta;
  end

endmodule

/* File: rtl/bbc_top.sv */
// Notes on behaviour
// - backlight on only with enable bit set and effective brightness >= 1
// - backlight enable bit reads 1 after reset
// - backlight held off until bias start-up has completed
// - all bias outputs off: start once bias boost has settled
// - bias boost enabled while bias pin or bias bit is high
// - sink one follows backlight; sink two also needs its own bit
// - brightness is high register as 8 msbs plus 3 lsbs of low
// - only a high register write applies a new brightness
// - select 00 uses register value, 01 uses measured pwm duty
// - select 10 multiplies before slope, 11 multiplies sloped value
// - register mode: zero brightness shuts the backlight down
// - pwm mode: pwm low for the timeout shuts the backlight down
// - combined modes: zero register or pwm timeout shuts down
// - bias pin tied low when the bias bit is used; bit honoured
// - strap picks one of two default sets; writes override them
// - active low reset returns control logic to defaults
// - open drain notify output signals power good or fault
// - select 00 ignores pwm zero; select 01 ignores register zero
// - select 10 slopes on pwm change; 11 changes immediately
// - pwm measurement disabled in register only mode
`timescale 1ns/10ps
module bbc_top #(
  parameter int PWM_TIMEOUT = bbc_pkg::PWM_TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_arst_n,
  // register link
  input  wire logic                   i_link_clk,
  input  wire logic                   i_link_req,
  input  wire bbc_pkg::bbc_req_s      i_link_cmd,
  output logic                        o_link_ready,
  output logic                        o_link_rvalid,
  output logic      [7:0]             o_link_rdata,
  // pins and analog status
  input  wire logic                   i_pwm,
  input  wire logic                   i_bias_pin,
  input  wire logic                   i_default_sel,
  input  wire logic                   i_rails_ready,
  input  wire logic                   i_outputs_off,
  input  wire logic                   i_boost_settled,
  input  wire logic                   i_fault,
  // drive
  output logic                        o_sink1_en,
  output logic                        o_sink2_en,
  output logic                        o_bias_boost_en,
  output logic      [bbc_pkg::BW-1:0] o_brightness,
  output logic                        o_notify_out,
  output logic                        o_notify_oe
);
  import bbc_pkg::*;

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_q1;
  logic rst_n;
  logic lrst_q1;
  logic lrst_n;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  always_ff @(posedge i_link_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lrst_q1 <= 1'b0;
      lrst_n  <= 1'b0;
    end else begin
      lrst_q1 <= 1'b1;
      lrst_n  <= lrst_q1;
    end
  end

  // ---------------------------------------------------------------
  // link domain
  // ---------------------------------------------------------------
  logic     req_tog;
  logic     busy;
  logic     ack_seen;
  logic     ack_sync;
  logic     ack_tog;
  logic     ack_new;
  bbc_req_s req_hold;
  logic [7:0] rdata;

  bbc_sync2 #(.W(1)) u_ack_sync (
    .i_clk (i_link_clk),
    .i_d   (ack_tog),
    .o_q   (ack_sync)
  );

  assign o_link_ready = !busy;
  assign ack_new      = ack_sync != ack_seen;

  // command held stable until the core answers
  always_ff @(posedge i_link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      req_tog       <= 1'b0;
      req_hold      <= '0;
      busy          <= 1'b0;
      ack_seen      <= 1'b0;
      o_link_rvalid <= 1'b0;
      o_link_rdata  <= 8'h00;
    end else begin
      o_link_rvalid <= 1'b0;
      if (i_link_req && !busy) begin
        req_hold <= i_link_cmd;
        req_tog  <= ~req_tog;
        busy     <= 1'b1;
      end else if (busy && ack_new) begin
        ack_seen      <= ack_sync;
        busy          <= 1'b0;
        o_link_rvalid <= !req_hold.wr;
        o_link_rdata  <= rdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [7:0] pins_sync;
  logic       req_sync;
  logic       pwm_s;
  logic       bias_pin_s;
  logic       def_sel_s;
  logic       rails_s;
  logic       outs_off_s;
  logic       settled_s;
  logic       fault_s;

  bbc_sync2 #(.W(8)) u_pin_sync (
    .i_clk (i_clk),
    .i_d   ({req_tog, i_pwm, i_bias_pin, i_default_sel,
             i_rails_ready, i_outputs_off, i_boost_settled,
             i_fault}),
    .o_q   (pins_sync)
  );

  assign {req_sync, pwm_s, bias_pin_s, def_sel_s,
          rails_s, outs_off_s, settled_s, fault_s} = pins_sync;

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  bbc_ctrl_s     ctrl;
  bbc_stat_s     stat;
  logic [7:0]    brt_lo;
  logic [7:0]    brt_hi;
  logic [BW-1:0] brt_applied;
  logic          loaded;
  logic          req_seen;
  logic          req_new;
  logic          wr_hit;

  assign req_new = loaded && (req_sync != req_seen);
  assign wr_hit  = req_new && req_hold.wr;

  function automatic logic [7:0] read_mux(
    input logic [7:0] addr,
    input logic [7:0] lo,
    input logic [7:0] hi,
    input bbc_ctrl_s  c,
    input bbc_stat_s  s
  );
    case (addr)
      ADDR_BRT_LO: read_mux = lo;
      ADDR_BRT_HI: read_mux = hi;
      ADDR_CTRL:   read_mux = c;
      ADDR_STAT:   read_mux = {4'h0, s};
      default:     read_mux = 8'h00;
    endcase
  endfunction

  // defaults loaded on the first cycle after release
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl        <= CTRL_DEF_A;
      brt_lo      <= BRT_LO_DEF_A;
      brt_hi      <= BRT_HI_DEF_A;
      brt_applied <= {BRT_HI_DEF_A, BRT_LO_DEF_A[2:0]};
      loaded      <= 1'b0;
    end else if (!loaded) begin
      loaded      <= 1'b1;
      ctrl        <= def_sel_s ? CTRL_DEF_B : CTRL_DEF_A;
      brt_lo      <= def_sel_s ? BRT_LO_DEF_B : BRT_LO_DEF_A;
      brt_hi      <= def_sel_s ? BRT_HI_DEF_B : BRT_HI_DEF_A;
      brt_applied <= def_sel_s ?
                     {BRT_HI_DEF_B, BRT_LO_DEF_B[2:0]} :
                     {BRT_HI_DEF_A, BRT_LO_DEF_A[2:0]};
    end else if (wr_hit) begin
      unique case (req_hold.addr)
        ADDR_BRT_LO: brt_lo <= req_hold.data;
        ADDR_BRT_HI: begin
          brt_hi      <= req_hold.data;
          brt_applied <= {req_hold.data, brt_lo[2:0]};
        end
        ADDR_CTRL:   ctrl <= {3'h0, req_hold.data[4:0]};
        default:     ;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_seen <= 1'b0;
      ack_tog  <= 1'b0;
      rdata    <= 8'h00;
    end else if (req_new) begin
      req_seen <= req_sync;
      ack_tog  <= ~ack_tog;
      rdata    <= read_mux(req_hold.addr, brt_lo, brt_hi, ctrl, stat);
    end
  end

  // ---------------------------------------------------------------
  // pwm duty measurement
  // ---------------------------------------------------------------
  logic [BW-1:0] duty;
  logic          pwm_tout;
  logic          pwm_en;

  assign pwm_en = ctrl.src_sel != SRC_REG;

  bbc_pwm_meas #(.TIMEOUT_CYC(CW'(PWM_TIMEOUT))) u_pwm (
    .i_clk     (i_clk),
    .i_rst_n   (rst_n),
    .i_en      (pwm_en),
    .i_pwm     (pwm_s),
    .o_duty    (duty),
    .o_timeout (pwm_tout)
  );

  // ---------------------------------------------------------------
  // source select and sloper
  // ---------------------------------------------------------------
  function automatic logic [BW-1:0] scale(
    input logic [BW-1:0] a,
    input logic [BW-1:0] b
  );
    logic [2*BW-1:0] p;
    p     = a * b;
    scale = p[2*BW-1:BW];
  endfunction

  logic [BW-1:0] target;
  logic [BW-1:0] sloped;
  logic [BW-1:0] next_bright;
  logic [2:0]    slope_cnt;
  logic          nonzero;
  logic          bias_ready;
  logic          next_on;

  always_comb begin
    unique case (ctrl.src_sel)
      SRC_REG: begin
        target      = brt_applied;
        next_bright = sloped;
        nonzero     = brt_applied != '0;
      end
      SRC_PWM: begin
        target      = duty;
        next_bright = sloped;
        nonzero     = !pwm_tout;
      end
      SRC_MUL_PRE: begin
        target      = scale(brt_applied, duty);
        next_bright = sloped;
        nonzero     = brt_applied != '0 && !pwm_tout;
      end
      SRC_MUL_POST: begin
        target      = brt_applied;
        next_bright = scale(sloped, duty);
        nonzero     = brt_applied != '0 && !pwm_tout;
      end
    endcase
  end

  // one code per step toward the target
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      sloped    <= '0;
      slope_cnt <= 3'h0;
    end else if (slope_cnt != 3'(SLOPE_STEP_CYC - 1)) begin
      slope_cnt <= slope_cnt + 3'h1;
    end else begin
      slope_cnt <= 3'h0;
      if (sloped < target) sloped <= sloped + BW'(1);
      else if (sloped > target) sloped <= sloped - BW'(1);
    end
  end

  // ---------------------------------------------------------------
  // backlight and bias outputs
  // ---------------------------------------------------------------
  assign bias_ready = outs_off_s ? settled_s : rails_s;
  assign next_on    = ctrl.backlight_on_bit && nonzero && bias_ready;
  assign stat       = '{fault:       fault_s,
                        pwm_timeout: pwm_tout,
                        bias_ready:  bias_ready,
                        bl_on:       o_sink1_en};
  assign o_notify_out = 1'b0;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_sink1_en   <= 1'b0;
      o_sink2_en   <= 1'b0;
      o_brightness <= '0;
    end else begin
      o_sink1_en   <= next_on;
      o_sink2_en   <= next_on && ctrl.sink2_en;
      o_brightness <= next_on ? next_bright : '0;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_bias_boost_en <= 1'b0;
      o_notify_oe     <= 1'b0;
    end else begin
      o_bias_boost_en <= bias_pin_s || ctrl.bias_en;
      o_notify_oe     <= fault_s || bias_ready;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  bl_on_cause_a: assert property (
    @(posedge i_clk) disable iff (!rst_n)
    $past(rst_n) |-> o_sink1_en == $past(ctrl.backlight_on_bit && nonzero && bias_ready))
    else $error("backlight state does not follow its causes");

  default_on_a: assert property (
    @(posedge i_clk) disable iff (!rst_n)
    $rose(loaded) |-> ctrl.backlight_on_bit)
    else $error("enable bit not set after reset");

  bias_gate_a: assert property (
    @(posedge i_clk) disable iff (!rst_n)
    !bias_ready |=> !o_sink1_en && !o_sink2_en)
    else $error("backlight on before bias start-up");

  boost_path_a: assert property (
    @(posedge i_clk) disable iff (!rst_n)
    outs_off_s && settled_s && ctrl.backlight_on_bit && nonzero
    |=> o_sink1_en)
    else $error("backlight did not start on settled boost");

  boost_en_a: assert property (
    @(posedge i_clk) disable iff (!rst_n)
    (bias_pin_s || ctrl.bias_en) |=> o_bias_boost_en)
    else $error("bias boost not enabled");

  sink_pair_a: assert property (
    @(posedge i_clk) disable iff (!rst_n)
    o_sink2_en |-> o_sink1_en && $past(ctrl.sink2_en))
    else $error("second sink on without first sink or bit");

  brt_commit_a: assert property (
    @(posedge i_clk) disable iff (!rst_n)
    wr_hit && req_hold.addr == ADDR_BRT_HI
    |=> brt_applied == {$past(req_hold.data), brt_lo[2:0]})
    else $error("brightness not committed on high write");

  low_hold_a: assert property (
    @(posedge i_clk) disable iff (!rst_n)
    loaded && !(wr_hit && req_hold.addr == ADDR_BRT_HI)
    |=> $stable(brt_applied))
    else $error("brightness changed without high write");

  pwm_off_a: assert property (
    @(posedge i_clk) disable iff (!rst_n)
    ctrl.src_sel == SRC_REG [*3] |-> duty == '0 && !pwm_tout)
    else $error("pwm measurement active in register mode");

  zero_off_a: assert property (
    @(posedge i_clk) disable iff (!rst_n)
    ctrl.src_sel == SRC_REG && brt_applied == '0 |=> !o_sink1_en)
    else $error("zero brightness left backlight on");

endmodule
